/* File: rtl/nco_iq_cfg_pkg.sv */
// Package of offsets, field positions, reset values and sync codes for the configuration bank.
package nco_iq_cfg_pkg;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam int REG_COUNT = 15;
    localparam logic [7:0] ADDR_FIRST = 8'h08;
    localparam logic [7:0] ADDR_LAST = 8'h16;
    localparam logic [7:0] OFS_FREQ_BYTE0 = 8'h08;
    localparam logic [7:0] OFS_FREQ_BYTE3 = 8'h0B;
    localparam logic [7:0] OFS_CHAN_A_GAIN_LOW = 8'h0C;
    localparam logic [7:0] OFS_CHAN_B_GAIN_LOW = 8'h0D;
    localparam logic [7:0] OFS_PHASE_CORR_LOW = 8'h0E;
    localparam logic [7:0] OFS_GAIN_PHASE_UPPER = 8'h0F;
    localparam logic [7:0] OFS_CHAN_A_OFFSET_LOW = 8'h10;
    localparam logic [7:0] OFS_CHAN_B_OFFSET_LOW = 8'h11;
    localparam logic [7:0] OFS_CHAN_A_OFFSET_HIGH = 8'h12;
    localparam logic [7:0] OFS_CHAN_B_OFFSET_HIGH = 8'h13;
    localparam logic [7:0] OFS_SERIAL_VALUE_LOW = 8'h14;
    localparam logic [7:0] OFS_SERIAL_VALUE_HIGH = 8'h15;
    localparam logic [7:0] OFS_SYNC_SOURCE_SELECT = 8'h16;

    // ************************************************************
    // Reset values and write masks, indexed by offset minus ADDR_FIRST.
    // ************************************************************
    localparam logic [7:0] RESET_GAIN_PHASE_UPPER = 8'h24;
    localparam logic [7:0] RESET_SYNC_SOURCE_SELECT = 8'h15;
    localparam logic [7:0] OFFSET_HIGH_MASK = 8'h1F;
    localparam logic [7:0] REG_RESET [0:14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        RESET_GAIN_PHASE_UPPER, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        RESET_SYNC_SOURCE_SELECT};
    localparam logic [7:0] REG_MASK [0:14] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, OFFSET_HIGH_MASK, OFFSET_HIGH_MASK, 8'hFF, 8'hFF, 8'hFF};

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int PHASE_HI_LSB = 6;
    localparam int PHASE_HI_W = 2;
    localparam int GAIN_A_HI_LSB = 3;
    localparam int GAIN_B_HI_LSB = 0;
    localparam int GAIN_HI_W = 3;
    localparam int OFFSET_HI_W = 5;
    localparam int SEL_FIELD_W = 2;
    localparam int GAIN_FRAC_BITS = 10;
    localparam int PHASE_SCALE_SHIFT = 12;

    // ************************************************************
    // Sync sources and setting groups.
    // ************************************************************
    typedef enum logic [1:0] {
        SYNC_TXEN = 2'h0,
        SYNC_PIN = 2'h1,
        SYNC_SIF = 2'h2,
        SYNC_ZERO = 2'h3
    } sync_src_t;

    localparam int GRP_OFFSET = 0;
    localparam int GRP_CORR = 1;
    localparam int GRP_NCO = 2;
    localparam int GRP_ACC = 3;
    localparam int GRP_COUNT = 4;
    localparam int SYNCED_COUNT = 12;
    localparam int NCO_LAST_IDX = 3;
    localparam int CORR_LAST_IDX = 7;

endpackage : nco_iq_cfg_pkg

/* File: rtl/sync_source_mux.sv */
// Selector that picks one sync source from a 2-bit code.
`timescale 1ns/1ps
module sync_source_mux (
    // Selection.
    input wire logic [1:0] sel,
    // Sources.
    input wire logic transmit_enable_pin,
    input wire logic sync_pin,
    input wire logic sif_sync,
    // Result.
    output wire logic sync_event
);
    wire logic pick_txen = (sel == nco_iq_cfg_pkg::SYNC_TXEN);
    wire logic pick_pin = (sel == nco_iq_cfg_pkg::SYNC_PIN);
    wire logic pick_sif = (sel == nco_iq_cfg_pkg::SYNC_SIF);

    // The constant-zero code never produces an event.
    assign sync_event = (pick_txen & transmit_enable_pin) | (pick_pin & sync_pin) |
        (pick_sif & sif_sync);
endmodule : sync_source_mux

/* File: rtl/nco_phase_accum.sv */
// Oscillator phase accumulator with phase offset and table address output.
`timescale 1ns/1ps
module nco_phase_accum #(
    parameter int ACC_W = 32,
    parameter int ADDR_W = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Settings.
    input wire logic [ACC_W-1:0] freq_word,
    input wire logic [ADDR_W-1:0] phase_offset,
    input wire logic acc_clear,
    // Table address.
    output logic [ADDR_W-1:0] table_addr
);
    initial begin
        if (ADDR_W > ACC_W) begin
            $error("Table address wider than accumulator.");
        end
    end

    logic [ACC_W-1:0] acc;
    wire logic [ACC_W-1:0] next_acc = acc_clear ? '0 : acc + freq_word;
    wire logic [ADDR_W-1:0] next_addr = acc[ACC_W-1 -: ADDR_W] + phase_offset;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= '0;
            table_addr <= '0;
        end else begin
            acc <= next_acc;
            table_addr <= next_addr;
        end
    end

    a_acc_clear_zero: assert property (@(posedge clk) disable iff (sys_rst)
        acc_clear |=> (acc == '0))
        else $error("Accumulator not cleared by its sync.");
endmodule : nco_phase_accum

/* File: rtl/nco_iq_correction_config_regs.sv */
// Configuration bank for oscillator, IQ correction, offset and serial value settings.
`timescale 1ns/1ps
module nco_iq_correction_config_regs #(
    parameter int SAMPLE_W = 16,
    parameter int FREQ_W = 32,
    parameter int TABLE_ADDR_W = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Register access from the serial control interface.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sync sources, already past the input FIFO.
    input wire logic transmit_enable_pin,
    input wire logic sync_pin,
    input wire logic sif_sync_bit,
    // Enables and phase offset from other configuration registers.
    input wire logic qmc_corr_enable,
    input wire logic qmc_offset_enable,
    input wire logic ser_value_enable,
    input wire logic [TABLE_ADDR_W-1:0] phase_offset,
    // Samples in.
    input wire logic signed [SAMPLE_W-1:0] i_sample,
    input wire logic signed [SAMPLE_W-1:0] q_sample,
    // Samples out and oscillator.
    output logic [SAMPLE_W-1:0] chan_a_out,
    output logic [SAMPLE_W-1:0] chan_b_out,
    output logic [TABLE_ADDR_W-1:0] nco_table_addr,
    output logic [FREQ_W-1:0] freq_word_active
);
    initial begin
        if (SAMPLE_W != 16 || FREQ_W != 32) begin
            $error("Sample width must be 16 and frequency word 32.");
        end
        if (TABLE_ADDR_W > FREQ_W) begin
            $error("Table address wider than frequency word.");
        end
    end

    localparam int SUM_W = SAMPLE_W + 3;
    localparam logic signed [SUM_W-1:0] SAT_MAX = SUM_W'(32767);
    localparam logic signed [SUM_W-1:0] SAT_MIN = -SUM_W'(32768);
    localparam int SEL_W = nco_iq_cfg_pkg::SEL_FIELD_W;
    localparam logic [10:0] GAIN_UNITY = 11'(1 << nco_iq_cfg_pkg::GAIN_FRAC_BITS);
    localparam int HALF_W = SAMPLE_W / 2;

    // ************************************************************
    // Address decode and shadow storage.
    // ************************************************************
    logic [7:0] shadow [0:14];
    logic [7:0] active [0:11];

    wire logic [7:0] reg_index = reg_addr - nco_iq_cfg_pkg::ADDR_FIRST;
    wire logic reg_mapped = (reg_addr >= nco_iq_cfg_pkg::ADDR_FIRST) &&
        (reg_addr <= nco_iq_cfg_pkg::ADDR_LAST);
    wire logic [7:0] next_rdata = reg_mapped ? shadow[reg_index[3:0]] : 8'h00;

    localparam int I_GAIN_A = nco_iq_cfg_pkg::OFS_CHAN_A_GAIN_LOW - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_GAIN_B = nco_iq_cfg_pkg::OFS_CHAN_B_GAIN_LOW - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_PHASE = nco_iq_cfg_pkg::OFS_PHASE_CORR_LOW - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_UPPER = nco_iq_cfg_pkg::OFS_GAIN_PHASE_UPPER - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_OFF_AL = nco_iq_cfg_pkg::OFS_CHAN_A_OFFSET_LOW - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_OFF_BL = nco_iq_cfg_pkg::OFS_CHAN_B_OFFSET_LOW - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_OFF_AH = nco_iq_cfg_pkg::OFS_CHAN_A_OFFSET_HIGH - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_OFF_BH = nco_iq_cfg_pkg::OFS_CHAN_B_OFFSET_HIGH - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_SER_L = nco_iq_cfg_pkg::OFS_SERIAL_VALUE_LOW - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_SER_H = nco_iq_cfg_pkg::OFS_SERIAL_VALUE_HIGH - nco_iq_cfg_pkg::ADDR_FIRST;
    localparam int I_SEL = nco_iq_cfg_pkg::OFS_SYNC_SOURCE_SELECT - nco_iq_cfg_pkg::ADDR_FIRST;

    genvar gi;
    generate
        for (gi = 0; gi < nco_iq_cfg_pkg::REG_COUNT; gi++) begin : g_shadow
            wire logic hit = reg_wr && reg_mapped && (reg_index == 8'(gi));
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    shadow[gi] <= nco_iq_cfg_pkg::REG_RESET[gi];
                end else if (hit) begin
                    shadow[gi] <= reg_wdata & nco_iq_cfg_pkg::REG_MASK[gi];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Sync selection.
    // ************************************************************
    logic [nco_iq_cfg_pkg::GRP_COUNT-1:0] grp_event;

    wire logic [1:0] sel_offset = shadow[I_SEL][nco_iq_cfg_pkg::GRP_OFFSET*SEL_W +: SEL_W];
    wire logic [1:0] sel_corr = shadow[I_SEL][nco_iq_cfg_pkg::GRP_CORR*SEL_W +: SEL_W];
    wire logic [1:0] sel_nco = shadow[I_SEL][nco_iq_cfg_pkg::GRP_NCO*SEL_W +: SEL_W];
    wire logic [1:0] sel_acc = shadow[I_SEL][nco_iq_cfg_pkg::GRP_ACC*SEL_W +: SEL_W];

    generate
        for (gi = 0; gi < nco_iq_cfg_pkg::GRP_COUNT; gi++) begin : g_sync
            // Group 3 accumulator, 2 frequency, 1 gain and phase, 0 offset.
            sync_source_mux u_mux (
                .sel(shadow[I_SEL][gi*nco_iq_cfg_pkg::SEL_FIELD_W +: nco_iq_cfg_pkg::SEL_FIELD_W]),
                .transmit_enable_pin(transmit_enable_pin),
                .sync_pin(sync_pin),
                .sif_sync(sif_sync_bit),
                .sync_event(grp_event[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Active copies of synced registers.
    // ************************************************************
    generate
        for (gi = 0; gi < nco_iq_cfg_pkg::SYNCED_COUNT; gi++) begin : g_active
            localparam int GRP = (gi <= nco_iq_cfg_pkg::NCO_LAST_IDX) ? nco_iq_cfg_pkg::GRP_NCO :
                (gi <= nco_iq_cfg_pkg::CORR_LAST_IDX) ? nco_iq_cfg_pkg::GRP_CORR :
                nco_iq_cfg_pkg::GRP_OFFSET;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    active[gi] <= nco_iq_cfg_pkg::REG_RESET[gi];
                end else if (grp_event[GRP]) begin
                    active[gi] <= shadow[gi];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Word assembly.
    // ************************************************************
    wire logic [FREQ_W-1:0] freq_word = {active[3], active[2], active[1], active[0]};
    wire logic [10:0] gain_a = {active[I_UPPER][nco_iq_cfg_pkg::GAIN_A_HI_LSB +:
        nco_iq_cfg_pkg::GAIN_HI_W], active[I_GAIN_A]};
    wire logic [10:0] gain_b = {active[I_UPPER][nco_iq_cfg_pkg::GAIN_B_HI_LSB +:
        nco_iq_cfg_pkg::GAIN_HI_W], active[I_GAIN_B]};
    wire logic signed [9:0] phase_word = {active[I_UPPER][nco_iq_cfg_pkg::PHASE_HI_LSB +:
        nco_iq_cfg_pkg::PHASE_HI_W], active[I_PHASE]};
    wire logic signed [12:0] offset_a = {active[I_OFF_AH][nco_iq_cfg_pkg::OFFSET_HI_W-1:0],
        active[I_OFF_AL]};
    wire logic signed [12:0] offset_b = {active[I_OFF_BH][nco_iq_cfg_pkg::OFFSET_HI_W-1:0],
        active[I_OFF_BL]};
    wire logic [SAMPLE_W-1:0] ser_word = {shadow[I_SER_H], shadow[I_SER_L]};

    // ************************************************************
    // Gain, phase and offset correction.
    // ************************************************************
    wire logic signed [27:0] prod_ia = i_sample * $signed({1'b0, gain_a});
    wire logic signed [27:0] prod_qb = q_sample * $signed({1'b0, gain_b});
    wire logic signed [25:0] prod_qp = q_sample * phase_word;
    wire logic signed [SUM_W-1:0] corr_i = SUM_W'(prod_ia >>> nco_iq_cfg_pkg::GAIN_FRAC_BITS) +
        SUM_W'(prod_qp >>> nco_iq_cfg_pkg::PHASE_SCALE_SHIFT);
    wire logic signed [SUM_W-1:0] corr_q = SUM_W'(prod_qb >>> nco_iq_cfg_pkg::GAIN_FRAC_BITS);
    wire logic signed [SUM_W-1:0] sel_i = qmc_corr_enable ? corr_i : SUM_W'(i_sample);
    wire logic signed [SUM_W-1:0] sel_q = qmc_corr_enable ? corr_q : SUM_W'(q_sample);
    wire logic signed [SUM_W-1:0] off_i = qmc_offset_enable ? sel_i + SUM_W'(offset_a) :
        sel_i;
    wire logic signed [SUM_W-1:0] off_q = qmc_offset_enable ? sel_q + SUM_W'(offset_b) :
        sel_q;

    function automatic logic [SAMPLE_W-1:0] sat_sample(input logic signed [SUM_W-1:0] v);
        if (v > SAT_MAX) begin
            return SAMPLE_W'(SAT_MAX);
        end else if (v < SAT_MIN) begin
            return SAMPLE_W'(SAT_MIN);
        end
        return SAMPLE_W'(v);
    endfunction : sat_sample

    wire logic [SAMPLE_W-1:0] next_chan_a = ser_value_enable ? ser_word : sat_sample(off_i);
    wire logic [SAMPLE_W-1:0] next_chan_b = ser_value_enable ? ser_word : sat_sample(off_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            chan_a_out <= '0;
            chan_b_out <= '0;
            freq_word_active <= '0;
        end else begin
            reg_rdata <= next_rdata;
            chan_a_out <= next_chan_a;
            chan_b_out <= next_chan_b;
            freq_word_active <= freq_word;
        end
    end

    // ************************************************************
    // Oscillator accumulator.
    // ************************************************************
    nco_phase_accum #(
        .ACC_W(FREQ_W),
        .ADDR_W(TABLE_ADDR_W)
    ) u_accum (
        .clk(clk),
        .sys_rst(sys_rst),
        .freq_word(freq_word),
        .phase_offset(phase_offset),
        .acc_clear(grp_event[nco_iq_cfg_pkg::GRP_ACC]),
        .table_addr(nco_table_addr)
    );

    // ************************************************************
    // Checks.
    // ************************************************************
    a_reset_values: assert property (@(posedge clk) $fell(sys_rst) |->
        (shadow[I_UPPER] == nco_iq_cfg_pkg::RESET_GAIN_PHASE_UPPER) && (gain_a == 11'h400))
        else $error("Upper correction register reset value wrong.");

    a_sel_reset_value: assert property (@(posedge clk) $fell(sys_rst) |->
        (shadow[I_SEL] == nco_iq_cfg_pkg::RESET_SYNC_SOURCE_SELECT))
        else $error("Sync selection reset value wrong.");

    a_freq_load: assert property (@(posedge clk) disable iff (sys_rst)
        grp_event[nco_iq_cfg_pkg::GRP_NCO] |=> ##1
        (freq_word_active == {$past(shadow[3], 2), $past(shadow[2], 2), $past(shadow[1], 2),
        $past(shadow[0], 2)}))
        else $error("Frequency word not loaded on its sync.");

    a_zero_sel_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (shadow[I_SEL][5:4] == nco_iq_cfg_pkg::SYNC_ZERO) |=> $stable(freq_word))
        else $error("Frequency word changed with constant-zero sync.");

    a_corr_sif_load: assert property (@(posedge clk) disable iff (sys_rst)
        ((shadow[I_SEL][3:2] == nco_iq_cfg_pkg::SYNC_SIF) && sif_sync_bit) |=>
        (active[I_UPPER] == $past(shadow[I_UPPER])))
        else $error("Correction group not loaded by software sync.");

    a_offset_pin_load: assert property (@(posedge clk) disable iff (sys_rst)
        ((shadow[I_SEL][1:0] == nco_iq_cfg_pkg::SYNC_PIN) && sync_pin) |=>
        (active[I_OFF_AL] == $past(shadow[I_OFF_AL])))
        else $error("Offset group not loaded by sync pin.");

    a_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_addr > nco_iq_cfg_pkg::ADDR_LAST) |=> (reg_rdata == 8'h00))
        else $error("Unmapped address did not read zero.");

    a_ser_override: assert property (@(posedge clk) disable iff (sys_rst)
        ser_value_enable |=> (chan_a_out == $past(ser_word)) && (chan_b_out == chan_a_out))
        else $error("Serial value not driving both channels.");

    a_plain_bypass: assert property (@(posedge clk) disable iff (sys_rst)
        (!qmc_corr_enable && !qmc_offset_enable && !ser_value_enable) |=>
        (chan_a_out == $past(i_sample)))
        else $error("Channel A altered with corrections off.");

    a_shadow_write: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_mapped) |=> (shadow[$past(reg_index[3:0])] ==
        ($past(reg_wdata) & nco_iq_cfg_pkg::REG_MASK[$past(reg_index[3:0])])))
        else $error("Write missed its shadow.");

    a_mask_offset_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && (reg_addr == nco_iq_cfg_pkg::OFS_CHAN_A_OFFSET_HIGH)) |=>
        ((shadow[I_OFF_AH] & ~nco_iq_cfg_pkg::OFFSET_HIGH_MASK) == 8'h00))
        else $error("Offset A high byte kept unused bits.");

    a_mask_offset_b: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && (reg_addr == nco_iq_cfg_pkg::OFS_CHAN_B_OFFSET_HIGH)) |=>
        ((shadow[I_OFF_BH] & ~nco_iq_cfg_pkg::OFFSET_HIGH_MASK) == 8'h00))
        else $error("Offset B high byte kept unused bits.");

    a_freq_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !grp_event[nco_iq_cfg_pkg::GRP_NCO] |=> $stable(freq_word))
        else $error("Frequency word moved without sync.");

    a_corr_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !grp_event[nco_iq_cfg_pkg::GRP_CORR] |=>
        ($stable(gain_a) && $stable(gain_b) && $stable(phase_word)))
        else $error("Correction words moved without sync.");

    a_offset_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !grp_event[nco_iq_cfg_pkg::GRP_OFFSET] |=> ($stable(offset_a) && $stable(offset_b)))
        else $error("Offset words moved without sync.");

    a_corr_pin_load: assert property (@(posedge clk) disable iff (sys_rst)
        ((sel_corr == nco_iq_cfg_pkg::SYNC_PIN) && sync_pin) |=>
        (active[I_GAIN_B] == $past(shadow[I_GAIN_B])))
        else $error("Correction group not loaded by sync pin.");

    a_acc_txen_clear: assert property (@(posedge clk) disable iff (sys_rst)
        ((sel_acc == nco_iq_cfg_pkg::SYNC_TXEN) && transmit_enable_pin) |=> ##1
        (nco_table_addr == $past(phase_offset)))
        else $error("Accumulator not cleared by transmit enable.");

    a_acc_zero_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (sel_acc == nco_iq_cfg_pkg::SYNC_ZERO) |-> !grp_event[nco_iq_cfg_pkg::GRP_ACC])
        else $error("Zero code raised accumulator sync.");

    a_nco_zero_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (sel_nco == nco_iq_cfg_pkg::SYNC_ZERO) |-> !grp_event[nco_iq_cfg_pkg::GRP_NCO])
        else $error("Zero code raised frequency sync.");

    a_off_zero_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (sel_offset == nco_iq_cfg_pkg::SYNC_ZERO) |-> !grp_event[nco_iq_cfg_pkg::GRP_OFFSET])
        else $error("Zero code raised offset sync.");

    a_ser_low: assert property (@(posedge clk) disable iff (sys_rst)
        (ser_value_enable && reg_wr && (reg_addr == nco_iq_cfg_pkg::OFS_SERIAL_VALUE_LOW)) ##1
        ser_value_enable |=> (chan_b_out[HALF_W-1:0] == $past(reg_wdata, 2)))
        else $error("Serial low byte not on channel B.");

    a_ser_high: assert property (@(posedge clk) disable iff (sys_rst)
        (ser_value_enable && reg_wr && (reg_addr == nco_iq_cfg_pkg::OFS_SERIAL_VALUE_HIGH)) ##1
        ser_value_enable |=> (chan_a_out[SAMPLE_W-1 -: HALF_W] == $past(reg_wdata, 2)))
        else $error("Serial high byte not on channel A.");

    a_unity_gain_b: assert property (@(posedge clk) disable iff (sys_rst)
        (qmc_corr_enable && !qmc_offset_enable && !ser_value_enable &&
        (gain_b == GAIN_UNITY)) |=> (chan_b_out == $past(q_sample)))
        else $error("Unity gain altered channel B.");

    a_bypass_b: assert property (@(posedge clk) disable iff (sys_rst)
        (!qmc_corr_enable && !qmc_offset_enable && !ser_value_enable) |=>
        (chan_b_out == $past(q_sample)))
        else $error("Channel B altered with corrections off.");

    a_offset_adds: assert property (@(posedge clk) disable iff (sys_rst)
        (!qmc_corr_enable && qmc_offset_enable && !ser_value_enable &&
        !q_sample[SAMPLE_W-1] && !q_sample[SAMPLE_W-2]) |=>
        (chan_b_out == $past(q_sample) + SAMPLE_W'($past(offset_b))))
        else $error("Channel B offset not added.");

    a_read_shadow: assert property (@(posedge clk) disable iff (sys_rst)
        reg_mapped |=> (reg_rdata == $past(shadow[reg_index[3:0]])))
        else $error("Read data not the addressed register.");
endmodule : nco_iq_correction_config_regs

/* File: tb/host_model.sv */
// Host controller model that writes and reads the bank over its byte access port.
`timescale 1ns/1ps
module host_model (
    // Clock.
    input wire logic clk,
    // Access port.
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // One write: strobe for a single cycle, then the data lines stop showing the value.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr_reg

    // One read: read data is registered, so it is taken one edge after the address.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd_reg
endmodule : host_model

/* File: tb/nco_iq_correction_config_regs_tb.sv */
// Self-checking bench for the oscillator and correction configuration bank.
`timescale 1ns/1ps
module nco_iq_correction_config_regs_tb;
    logic clk;
    logic sys_rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, ex;
    logic reg_wr, txen, syncp, sifb, corr_en, off_en, ser_en;
    logic [15:0] ph_off, a_out, b_out, t_addr, prev;
    logic signed [15:0] i_s, q_s;
    logic [31:0] f_act, fw, cur;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    nco_iq_correction_config_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .transmit_enable_pin(txen), .sync_pin(syncp), .sif_sync_bit(sifb),
        .qmc_corr_enable(corr_en), .qmc_offset_enable(off_en), .ser_value_enable(ser_en),
        .phase_offset(ph_off), .i_sample(i_s), .q_sample(q_s), .chan_a_out(a_out),
        .chan_b_out(b_out), .nco_table_addr(t_addr), .freq_word_active(f_act));

    // ************************************************************
    // Clock, timeout and shared tasks.
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Raises one sync source for a single cycle: 0 transmit enable, 1 pin, 2 software bit.
    task automatic pulse(input int s);
        @(negedge clk);
        txen = (s == 0);
        syncp = (s == 1);
        sifb = (s == 2);
        @(negedge clk);
        txen = 1'b0;
        syncp = 1'b0;
        sifb = 1'b0;
        repeat (3) @(negedge clk);
    endtask : pulse

    task automatic settle(input logic [15:0] ea, input logic [15:0] eb);
        repeat (3) @(negedge clk);
        check("chan_a_out", {16'h0, a_out}, {16'h0, ea});
        check("chan_b_out", {16'h0, b_out}, {16'h0, eb});
    endtask : settle

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        {txen, syncp, sifb, corr_en, off_en, ser_en} = 6'h00;
        ph_off = 16'h0000;
        i_s = 16'sh0000;
        q_s = 16'sh0000;
        cur = 32'h0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        // Reset values of every register, then write and read back each one.
        for (int a = 8; a <= 22; a++) begin
            ex = (a == 15) ? 8'h24 : (a == 22) ? 8'h15 : 8'h00;
            host.rd_reg(8'(a), rd);
            check("reset value", {24'h0, rd}, {24'h0, ex});
        end
        for (int a = 8; a <= 22; a++) begin
            ex = (a == 22) ? 8'hE4 : 8'(a) ^ 8'hA5;
            host.wr_reg(8'(a), ex);
            host.rd_reg(8'(a), rd);
            ex = (a == 18 || a == 19) ? (ex & 8'h1F) : ex;
            check("readback", {24'h0, rd}, {24'h0, ex});
        end
        host.wr_reg(8'h17, 8'h5A);
        host.rd_reg(8'h17, rd);
        check("unmapped", {24'h0, rd}, 32'h0);
        // Frequency group loads only on its selected source; code 11 never loads.
        for (int c = 0; c < 4; c++) begin
            host.wr_reg(8'h16, {2'b11, c[1:0], 4'h9});
            fw = 32'hF1E2D3C4 + 32'(c);
            for (int b = 0; b < 4; b++) host.wr_reg(8'(8 + b), fw[8*b +: 8]);
            for (int s = 0; s < 3; s++) begin
                pulse(s);
                if (s == c) cur = fw;
                check("freq_word", f_act, cur);
            end
        end
        // Gain 0.5 on both channels, phase 64, offsets -240 and +5.
        host.wr_reg(8'h16, 8'h15);
        host.wr_reg(8'h0C, 8'h00);
        host.wr_reg(8'h0D, 8'h00);
        host.wr_reg(8'h0E, 8'h40);
        host.wr_reg(8'h0F, 8'h12);
        host.wr_reg(8'h10, 8'h10);
        host.wr_reg(8'h11, 8'h05);
        host.wr_reg(8'h12, 8'h1F);
        host.wr_reg(8'h13, 8'h00);
        pulse(1);
        i_s = 16'sd1000;
        q_s = 16'sd6400;
        corr_en = 1'b1;
        settle(16'd600, 16'd3200);
        host.wr_reg(8'h0F, 8'h24);
        pulse(1);
        settle(16'd1100, 16'd6400);
        corr_en = 1'b0;
        off_en = 1'b1;
        settle(16'd760, 16'd6405);
        off_en = 1'b0;
        settle(16'd1000, 16'd6400);
        ser_en = 1'b1;
        host.wr_reg(8'h14, 8'hCD);
        host.wr_reg(8'h15, 8'hAB);
        settle(16'hABCD, 16'hABCD);
        ser_en = 1'b0;
        // Accumulator: one table step per cycle, cleared while transmit enable is high only with select code 00.
        for (int b = 0; b < 4; b++) host.wr_reg(8'(8 + b), (b == 2) ? 8'h01 : 8'h00);
        pulse(1);
        ph_off = 16'h1234;
        txen = 1'b1;
        repeat (3) @(negedge clk);
        check("table_addr", {16'h0, t_addr}, 32'h1234);
        txen = 1'b0;
        repeat (4) @(negedge clk);
        prev = t_addr;
        @(negedge clk);
        check("table_step", {16'h0, t_addr}, {16'h0, prev + 16'h1});
        host.wr_reg(8'h16, 8'hD5);
        txen = 1'b1;
        repeat (3) @(negedge clk);
        prev = t_addr;
        @(negedge clk);
        check("no_clear", {16'h0, t_addr}, {16'h0, prev + 16'h1});
        txen = 1'b0;
        test_done();
    end
endmodule : nco_iq_correction_config_regs_tb
